// File: core/tss_sequencer.sv
// Tracking supply sequencer top with AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_sequencer (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [3:0] i_chan_run_input,
  input wire logic i_input_supply_low,
  input wire logic i_share_clk_low,
  input wire logic [3:0] i_undervoltage_event,
  input wire logic [3:0] i_undercurrent_event,
  input wire logic [3:0] i_ov_fault,
  output logic [3:0] o_converter_run_output,
  output logic [3:0] o_detect_mask,
  output logic [3:0] o_power_good,
  output logic o_irq
);
  // Pin synchronisers
  logic [14:0] sync1_reg;
  logic [14:0] sync2_reg;
  wire logic [14:0] pins = {i_input_supply_low, i_share_clk_low, i_ov_fault,
    i_undercurrent_event, i_undervoltage_event};
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1_reg <= 15'h0000;
      sync2_reg <= 15'h0000;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  logic [3:0] run_sync1_reg;
  logic [3:0] run_sync2_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      run_sync1_reg <= 4'h0;
      run_sync2_reg <= 4'h0;
    end else begin
      run_sync1_reg <= i_chan_run_input;
      run_sync2_reg <= run_sync1_reg;
    end
  end
  wire logic [3:0] uv_s = sync2_reg[3:0];
  wire logic [3:0] uc_s = sync2_reg[7:4];
  wire logic [3:0] ov_s = sync2_reg[11:8];
  wire logic share_low_s = sync2_reg[12];
  wire logic vin_low_s = sync2_reg[13];

  // AHB-Lite slave
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  wire logic ahb_go = i_hsel && i_hready && i_htrans[1];
  wire logic ahb_wr = wr_pend_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= ahb_go && i_hwrite;
      addr_reg <= ahb_go ? i_haddr : addr_reg;
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Registers
  logic [15:0] cfg_all_reg;
  logic [3:0] track_reg;
  logic [15:0] ton_dly_reg;
  logic [15:0] ton_rise_reg;
  logic [15:0] toff_dly_reg;
  logic [3:0] sw_run_reg;
  logic restore_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_en_reg;
  wire logic wr_cfg = ahb_wr && addr_reg == `TSS_OFF_CFG_ALL;
  wire logic wr_trk = ahb_wr && addr_reg == `TSS_OFF_TRACK;
  wire logic wr_ton = ahb_wr && addr_reg == `TSS_OFF_TON_DLY;
  wire logic wr_rise = ahb_wr && addr_reg == `TSS_OFF_TON_RISE;
  wire logic wr_toff = ahb_wr && addr_reg == `TSS_OFF_TOFF_DLY;
  wire logic wr_ctrl = ahb_wr && addr_reg == `TSS_OFF_CTRL;
  wire logic wr_en = ahb_wr && addr_reg == `TSS_OFF_IRQ_EN;
  wire logic wr_clr = ahb_wr && addr_reg == `TSS_OFF_IRQ_CLR;
  // Timing registers hold one channel each, indexed by the upper half-word
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg_all_reg <= `TSS_CFG_RESET;
      track_reg <= 4'h0;
      sw_run_reg <= 4'h0;
      restore_reg <= 1'b0;
      irq_en_reg <= 4'h0;
    end else begin
      if (wr_cfg) cfg_all_reg <= i_hwdata[15:0] & `TSS_CFG_WMASK;
      if (wr_trk) track_reg <= i_hwdata[3:0];
      if (wr_ctrl) sw_run_reg <= i_hwdata[3:0];
      restore_reg <= wr_ctrl && i_hwdata[4];
      if (wr_en) irq_en_reg <= i_hwdata[3:0];
    end
  end
  logic [15:0] ton_mem [0:3];
  logic [15:0] rise_mem [0:3];
  logic [15:0] toff_mem [0:3];
  always_ff @(posedge i_clock) begin
    if (wr_ton) ton_mem[i_hwdata[17:16]] <= i_hwdata[15:0];
    if (wr_rise) rise_mem[i_hwdata[17:16]] <= i_hwdata[15:0];
    if (wr_toff) toff_mem[i_hwdata[17:16]] <= i_hwdata[15:0];
  end

  // Timebase tick of one microsecond
  logic [4:0] tick_cnt_reg;
  wire logic tick = (tick_cnt_reg == 5'(`TSS_TICK_CYC - 1));
  always_ff @(posedge i_clock) begin
    if (i_rst) tick_cnt_reg <= 5'h00;
    else tick_cnt_reg <= tick ? 5'h00 : tick_cnt_reg + 5'h01;
  end

  // Group shutdown: any fault, input loss, shared clock low or restore
  tss_pkg::tss_chan_out_t chan_out [0:3];
  logic [3:0] fault_vec;
  logic [3:0] run_vec;
  logic [3:0] mask_vec;
  wire logic any_fault = |fault_vec || |ov_s;
  wire logic share_off = share_low_s && cfg_all_reg[3];
  wire logic group_down = any_fault || vin_low_s || share_off || restore_reg;
  wire logic hard_off = vin_low_s || share_off || restore_reg;
  // Polarity: 0 means low starts the channel
  wire logic [3:0] pin_pol = {cfg_all_reg[`TSS_BIT_POL3], cfg_all_reg[`TSS_BIT_POL2],
    cfg_all_reg[5], cfg_all_reg[4]};
  wire logic [3:0] pin_start = ~(run_sync2_reg ^ pin_pol);
  logic latched_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst) latched_reg <= 1'b0;
    else if (wr_ctrl) latched_reg <= 1'b0;
    else if (group_down) latched_reg <= 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < `TSS_NCHAN; g++) begin : gen_chan
      tss_pkg::tss_chan_cfg_t cfg;
      tss_pkg::tss_chan_in_t cin;
      assign cfg.ton_delay = ton_mem[g];
      assign cfg.ton_rise = rise_mem[g];
      assign cfg.toff_delay = toff_mem[g];
      assign cfg.track_en = track_reg[g];
      assign cin.run_req = sw_run_reg[g] && pin_start[g] && !latched_reg;
      assign cin.group_down = group_down || latched_reg;
      assign cin.hard_off = hard_off;
      assign cin.uv = uv_s[g];
      assign cin.uc = uc_s[g];
      tss_channel u_chan (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_tick(tick),
        .i_cfg(cfg),
        .i_in(cin),
        .o_out(chan_out[g])
      );
      assign fault_vec[g] = chan_out[g].fault;
      assign run_vec[g] = chan_out[g].run;
      assign mask_vec[g] = chan_out[g].mask;
    end
  endgenerate

  // Power good de-assert path: fast uses the supervisor, slow waits on a long filter
  logic [3:0] pg_reg;
  logic [21:0] pg_slow_reg;
  logic [7:0] pg_fast_reg;
  wire logic any_low = |(uv_s & ~mask_vec & run_vec);
  wire logic use_fast = cfg_all_reg[`TSS_BIT_PG_SRC];
  wire logic pg_drop = use_fast ? (pg_fast_reg == 8'(`TSS_FAST_PG_CYC - 1))
    : (pg_slow_reg == 22'(`TSS_SLOW_PG_CYC - 1));
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pg_reg <= 4'h0;
      pg_slow_reg <= 22'h000000;
      pg_fast_reg <= 8'h00;
    end else begin
      pg_fast_reg <= any_low && !pg_drop ? pg_fast_reg + 8'h01 : 8'h00;
      pg_slow_reg <= any_low && !pg_drop ? pg_slow_reg + 22'h000001 : 22'h000000;
      pg_reg <= pg_drop ? (pg_reg & ~uv_s) : (run_vec & ~mask_vec & ~uv_s) | (pg_reg & run_vec);
    end
  end

  // Sticky fault status, set wins over clear
  always_ff @(posedge i_clock) begin
    if (i_rst) irq_stat_reg <= 4'h0;
    else irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? i_hwdata[3:0] : 4'h0)) | fault_vec;
  end

  // Read mux
  logic [31:0] rdata_reg;
  wire logic [31:0] rsel =
    (i_haddr == `TSS_OFF_CFG_ALL) ? {16'h0000, cfg_all_reg & `TSS_CFG_WMASK} :
    (i_haddr == `TSS_OFF_TRACK) ? {28'h0000000, track_reg} :
    (i_haddr == `TSS_OFF_CTRL) ? {27'h0000000, 1'b0, sw_run_reg} :
    (i_haddr == `TSS_OFF_STATE) ? {19'h00000, latched_reg, pg_reg, mask_vec, run_vec} :
    (i_haddr == `TSS_OFF_IRQ_STAT) ? {28'h0000000, irq_stat_reg} :
    (i_haddr == `TSS_OFF_IRQ_EN) ? {28'h0000000, irq_en_reg} : 32'h00000000;
  always_ff @(posedge i_clock) begin
    if (i_rst) rdata_reg <= 32'h00000000;
    else if (ahb_go && !i_hwrite) rdata_reg <= rsel;
  end
  assign o_hrdata = rdata_reg;
  assign o_converter_run_output = run_vec;
  assign o_detect_mask = mask_vec;
  assign o_power_good = pg_reg;
  assign o_irq = |(irq_stat_reg & irq_en_reg);
endmodule // tss_sequencer

// File: core/tss_consts.svh
// Register offsets, field positions, reset values and timing counts for the sequencer
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
`define TSS_OFF_CFG_ALL 8'h00
`define TSS_OFF_TRACK 8'h04
`define TSS_OFF_TON_DLY 8'h08
`define TSS_OFF_TON_RISE 8'h0c
`define TSS_OFF_TOFF_DLY 8'h10
`define TSS_OFF_CTRL 8'h14
`define TSS_OFF_STATE 8'h18
`define TSS_OFF_IRQ_STAT 8'h1c
`define TSS_OFF_IRQ_EN 8'h20
`define TSS_OFF_IRQ_CLR 8'h24
`define TSS_CFG_WMASK 16'h0fff
`define TSS_CFG_RESET 16'h0000
`define TSS_BIT_PG_SRC 11
`define TSS_BIT_POL3 9
`define TSS_BIT_POL2 8
`define TSS_NCHAN 4
`define TSS_TICK_NS 1000
`define TSS_CLK_NS 50
`define TSS_TICK_CYC (`TSS_TICK_NS / `TSS_CLK_NS)
`define TSS_FAST_PG_US 12
`define TSS_FAST_PG_CYC ((`TSS_FAST_PG_US * 1000) / `TSS_CLK_NS)
`define TSS_SLOW_PG_MS 100
`define TSS_SLOW_PG_CYC ((`TSS_SLOW_PG_MS * 1000000) / `TSS_CLK_NS)
`endif

// File: core/tss_pkg.sv
// Types shared by the sequencer files
package tss_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_DLY,
    ST_RISE,
    ST_ON,
    ST_OFF_DLY
  } tss_state_t;
  typedef struct packed {
    logic [15:0] ton_delay;
    logic [15:0] ton_rise;
    logic [15:0] toff_delay;
    logic track_en;
  } tss_chan_cfg_t;
  typedef struct packed {
    logic run_req;
    logic group_down;
    logic hard_off;
    logic uv;
    logic uc;
  } tss_chan_in_t;
  typedef struct packed {
    logic run;
    logic mask;
    logic fault;
    logic [2:0] state;
  } tss_chan_out_t;
endpackage

// File: core/tss_channel.sv
// One channel sequencer: on delay, rise window, on, off delay
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_channel (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire tss_pkg::tss_chan_cfg_t i_cfg,
  input wire tss_pkg::tss_chan_in_t i_in,
  output tss_pkg::tss_chan_out_t o_out
);
  tss_pkg::tss_state_t state_reg;
  tss_pkg::tss_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic fault_reg;
  wire logic cnt_done = (cnt_reg == 16'h0000);
  wire logic det_mask = (state_reg == tss_pkg::ST_RISE) ||
    (i_cfg.track_en && state_reg == tss_pkg::ST_OFF_DLY);
  wire logic det_fault = !det_mask && (state_reg == tss_pkg::ST_ON) && (i_in.uv || i_in.uc);
  always_comb begin
    state_next = state_reg;
    cnt_next = (i_tick && !cnt_done) ? cnt_reg - 16'h0001 : cnt_reg;
    case (state_reg)
      tss_pkg::ST_OFF: begin
        if (i_in.run_req && !i_in.group_down) begin
          state_next = tss_pkg::ST_ON_DLY;
          cnt_next = i_cfg.ton_delay;
        end
      end
      tss_pkg::ST_ON_DLY, tss_pkg::ST_RISE, tss_pkg::ST_ON: begin
        if (i_in.group_down && i_cfg.track_en) begin
          state_next = tss_pkg::ST_OFF_DLY;
          cnt_next = i_cfg.toff_delay;
        end else if (i_in.hard_off) begin
          state_next = tss_pkg::ST_OFF;
        end else if (!i_in.run_req) begin
          state_next = tss_pkg::ST_OFF_DLY;
          cnt_next = i_cfg.toff_delay;
        end else if (state_reg == tss_pkg::ST_ON_DLY && cnt_done) begin
          state_next = tss_pkg::ST_RISE;
          cnt_next = i_cfg.ton_rise;
        end else if (state_reg == tss_pkg::ST_RISE && cnt_done) begin
          state_next = tss_pkg::ST_ON;
        end
      end
      tss_pkg::ST_OFF_DLY: begin
        if (cnt_done || (i_in.hard_off && !i_cfg.track_en)) begin
          state_next = tss_pkg::ST_OFF;
        end
      end
      default: state_next = tss_pkg::ST_OFF;
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= tss_pkg::ST_OFF;
      cnt_reg <= 16'h0000;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      fault_reg <= det_fault;
    end
  end
  // Run stays high through the off delay so the group falls in order
  assign o_out.run = (state_reg == tss_pkg::ST_RISE) || (state_reg == tss_pkg::ST_ON) ||
    (state_reg == tss_pkg::ST_OFF_DLY);
  assign o_out.mask = det_mask;
  assign o_out.fault = fault_reg;
  assign o_out.state = state_reg;
endmodule // tss_channel

// File: tb/tss_sequencer_chk.sv
// Port assertions for the tracking sequencer
`timescale 1ns/1ps
module tss_sequencer_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [3:0] o_converter_run_output,
  input wire logic [3:0] o_detect_mask,
  input wire logic o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire rd_take = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  wire [3:0] run = o_converter_run_output;
  a_ready_always: assert property (o_hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!o_hresp)
    else $error("error response");
  a_reset_clears: assert property ($fell(i_rst) |-> run == 4'h0 && !o_irq)
    else $error("run or irq not cleared");
  a_reset_rdata: assert property ($fell(i_rst) |-> o_hrdata == 32'h0)
    else $error("read data not cleared");
  a_rise_masked: assert property ((run & ~$past(run) & ~o_detect_mask) == 4'h0)
    else $error("run rose unmasked");
  a_mask_with_run: assert property ((o_detect_mask & ~run) == 4'h0)
    else $error("mask without run");
  a_cfg_rsvd_zero: assert property (rd_take && i_haddr == 8'h00 |=> o_hrdata[31:12] == 20'h0)
    else $error("reserved bits nonzero");
  a_unmapped_zero: assert property (rd_take && i_haddr > 8'h24 |=> o_hrdata == 32'h0)
    else $error("unmapped read nonzero");
  cover property ($rose(o_irq));
  cover property ($fell(run[0]) && run[1]);
  cover property ($rose(o_detect_mask[1]));
endmodule // tss_sequencer_chk
bind tss_sequencer tss_sequencer_chk u_chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_converter_run_output(o_converter_run_output), .o_detect_mask(o_detect_mask),
  .o_irq(o_irq));

// File: tb/tss_conv_model.sv
// Converter bank: outputs ramp after run, slaves track the master
`timescale 1ns/1ps
module tss_conv_model #(parameter int RAMP = 10) (
  input wire logic i_clock,
  input wire logic [3:0] i_run,
  input wire logic [3:0] i_fail,
  output logic [3:0] o_uv,
  output logic [3:0] o_uc
);
  int cnt[4];
  logic [3:0] up;
  always @(posedge i_clock) begin
    for (int k = 0; k < 4; k++) begin
      cnt[k] <= i_run[k] ? (cnt[k] < RAMP ? cnt[k] + 1 : RAMP) : 0;
    end
  end
  // Slaves fall with the master, so off delays must cover its fall
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      up[k] = cnt[k] == RAMP && (k == 0 || cnt[0] == RAMP);
    end
  end
  assign o_uv = ~up | i_fail;
  assign o_uc = ~up;
endmodule // tss_conv_model

// File: tb/tb_tss_sequencer.sv
// Self-checking bench for the tracking sequencer
`timescale 1ns/1ps
`include "tss_consts.svh"
module tb_tss_sequencer;
  logic i_clock, i_rst, hsel, hwrite, rdy, irq, vlow, slow;
  logic [1:0] htrans;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] pins, run, uv, uc, fail, pg, mask;
  logic [15:0] lf;
  logic [31:0] mdl [16];
  int failures, checks_done, toff[4], fall[4];
  tss_sequencer u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
    .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(), .i_chan_run_input(pins),
    .i_input_supply_low(vlow), .i_share_clk_low(slow), .i_undervoltage_event(uv),
    .i_undercurrent_event(uc), .i_ov_fault(4'h0), .o_converter_run_output(run),
    .o_detect_mask(mask), .o_power_good(pg), .o_irq(irq));
  tss_conv_model u_conv (.i_clock(i_clock), .i_run(run), .i_fail(fail), .o_uv(uv), .o_uc(uc));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task summarize;
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clock); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (rdy !== 1'b1);
    rd = hrdata;
    if (w && a == 8'h00) mdl[0] = d & {16'h0, `TSS_CFG_WMASK};
    if (w && (a == 8'h04 || a == 8'h20)) mdl[a[5:2]] = d & 32'hf;
  endtask
  task rdm(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    chk("register", mdl[a[5:2]], rd);
  endtask
  task chkirq(input logic e);
    repeat (2) @(posedge i_clock);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // Restore sets the group latch; the CTRL run write clears it before every restart
  task start(input logic [3:0] p);
    bus(1'b1, `TSS_OFF_CTRL, 32'h10);
    for (int k = 1; k < 4; k++) begin
      lf = nx(lf);
      toff[k] = 3 + lf[1:0];
      bus(1'b1, `TSS_OFF_TOFF_DLY, (k << 16) | toff[k]);
    end
    pins <= p;
    bus(1'b1, `TSS_OFF_CTRL, 32'hf);
    repeat (200) @(posedge i_clock);
    chk("run", {28'h0, p ~^ {mdl[0][9], mdl[0][8], mdl[0][5], mdl[0][4]}}, {28'h0, run});
    chkirq(1'b0);
  endtask
  task measure(input int lim);
    fall = '{default: -1};
    for (int c = 0; c < 400; c++) begin
      @(posedge i_clock);
      for (int k = 0; k < 4; k++) if (fall[k] < 0 && !run[k]) fall[k] = c;
    end
    for (int k = 2; k < 4; k++) begin
      chk("spacing", (toff[k] - toff[1]) * `TSS_TICK_CYC, fall[k] - fall[1]);
    end
    chk("order", 1, fall[0] < fall[1] && fall[0] < lim && fall[1] > 20);
  endtask
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  initial begin
    {i_rst, hsel, hwrite, vlow, slow} = 5'h10;
    htrans = 2'h0;
    haddr = 8'h0;
    hwdata = 32'h0;
    pins = 4'hf;
    fail = 4'h0;
    lf = 16'h5e27;
    mdl = '{default: 32'h0};
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int i = 0; i < 16; i += 7) rdm(8'(i * 4));
    bus(1'b1, 8'h00, 32'hffffffff);
    rdm(8'h00);
    bus(1'b1, 8'h3c, 32'hffffffff);
    rdm(8'h3c);
    bus(1'b1, 8'h00, 32'h0a38);
    rdm(8'h00);
    bus(1'b1, 8'h04, 32'he);
    rdm(8'h04);
    bus(1'b1, 8'h20, 32'hf);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `TSS_OFF_TON_DLY, (k << 16) | (k ? 1 : 4));
      bus(1'b1, `TSS_OFF_TON_RISE, (k << 16) | (k ? 6 : 2));
    end
    bus(1'b1, `TSS_OFF_TOFF_DLY, 32'h1);
    start(4'hf);
    pins <= 4'hb;
    repeat (200) @(posedge i_clock);
    chk("run", 32'hf, {28'h0, run});
    chk("mask", 32'h0, {28'h0, mask});
    chk("power_good", 32'hf, {28'h0, pg});
    fail <= 4'h2;
    measure(400);
    fail <= 4'h0;
    mdl[7] = 32'h2;
    rdm(`TSS_OFF_IRQ_STAT);
    chkirq(1'b1);
    bus(1'b1, `TSS_OFF_IRQ_EN, 32'h0);
    chkirq(1'b0);
    bus(1'b1, `TSS_OFF_IRQ_EN, 32'hf);
    chkirq(1'b1);
    bus(1'b1, `TSS_OFF_IRQ_CLR, 32'h2);
    chkirq(1'b0);
    mdl[7] = 32'h0;
    rdm(`TSS_OFF_IRQ_STAT);
    for (int e = 0; e < 3; e++) begin
      start(4'hb);
      if (e == 0) vlow <= 1'b1;
      if (e == 1) slow <= 1'b1;
      if (e == 2) bus(1'b1, `TSS_OFF_CTRL, 32'h1f);
      measure(8);
      vlow <= 1'b0;
      slow <= 1'b0;
    end
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    mdl = '{default: 32'h0};
    rdm(8'h00);
    summarize();
  end
endmodule // tb_tss_sequencer
